/* File: verilog/ctwd_pkg.sv */
// Package of constants for the clock timer and watchdog block
package ctwd_pkg;
  // Register byte addresses (index times four)
  localparam logic [15:0] CTWD_IDX_WDCTL  = 16'hFF07;
  localparam logic [15:0] CTWD_IDX_MASK   = 16'hFFE6;
  localparam logic [15:0] CTWD_IDX_FLAG   = 16'hFFF6;
  localparam logic [17:0] CTWD_ADDR_WDCTL = {CTWD_IDX_WDCTL, 2'b00};
  localparam logic [17:0] CTWD_ADDR_MASK  = {CTWD_IDX_MASK, 2'b00};
  localparam logic [17:0] CTWD_ADDR_FLAG  = {CTWD_IDX_FLAG, 2'b00};
  localparam logic [17:0] CTWD_ADDR_STAT  = 18'h00010;
  // Field positions
  localparam int CTWD_BIT_RESTART = 0;
  localparam int CTWD_BIT_ENABLE  = 1;
  localparam int CTWD_BIT_MASK    = 0;
  localparam int CTWD_BIT_FLAG    = 0;
  // Reset values
  localparam logic CTWD_RST_ENABLE = 1'b1;
  localparam logic CTWD_RST_MASK   = 1'b0;
  localparam logic CTWD_RST_FLAG   = 1'b0;
  // Prescaler divide base, counter and setting widths, NMI vector
  localparam int CTWD_PRS_BASE   = 2048;
  localparam int CTWD_TMR_WIDTH  = 8;
  localparam int CTWD_WD_WIDTH   = 2;
  localparam int CTWD_PRESCALER_SETTING_WIDTH = 4;
  localparam logic [15:0] CTWD_NMI_VECTOR = 16'h0100;
endpackage

/* File: verilog/ctwd_timer.sv */
// Clock timer with one-second tick and program-overrun watchdog
// Function
// R01: Eight-bit up-counter at prescaled 256 Hz rate
// R02: Input rate is oscillator over 2048 times n
// R03: Counts in halt, stops while sleeping
// R04: Tick falling edge sets flag, requests interrupt
// R05: Mask gates request only, flag always set
// R06: Watchdog is two-bit counter on tick
// R07: Watchdog overflow issues non-maskable interrupt
// R08: Watchdog enabled after reset; software may disable
// R09: Restart write clears watchdog counter
// R10: Restart to overflow three to four periods
// R11: Watchdog counts in halt; NMI releases halt
// R12: Watchdog held cleared during sleep
// R13: NMI ignores I flag, waits stack pointer pair
// R14: NMI vectors to address 0100H
// R15: Enable read/write reset one, restart reads zero
// R16: Mask bit 0 read/write, resets zero
// R17: Unused bits ignore writes, read zero
// R18: Flag cleared by writing one
// R19: Restart resumes immediately; disabled means no count
// R20: Reset clears both counters
`timescale 1ns/1ps
module ctwd_timer
  import ctwd_pkg::*;
#(
  parameter int PRS_BASE = CTWD_PRS_BASE
) (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        clk_en,
  input  wire logic [17:0] avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  output logic      [1:0]  avs_response,
  input  wire logic [3:0]  prescaler_setting,
  input  wire logic        sleep_mode,
  input  wire logic        stack_pointer_low_half,
  input  wire logic        stack_pointer_high_half,
  output logic             second_tick_irq,
  output logic             watchdog_nmi,
  output logic      [15:0] nmi_vector,
  output logic             halt_release
);

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers for pins from the core's slower domains
  logic [1:0] sleep_sync_r;
  logic [1:0] spl_sync_r;
  logic [1:0] sph_sync_r;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sleep_sync_r <= 2'h0;
      spl_sync_r   <= 2'h0;
      sph_sync_r   <= 2'h0;
    end else if (clk_en) begin
      sleep_sync_r <= {sleep_sync_r[0], sleep_mode};
      spl_sync_r   <= {spl_sync_r[0], stack_pointer_low_half};
      sph_sync_r   <= {sph_sync_r[0], stack_pointer_high_half};
    end
  end
  wire sleeping = sleep_sync_r[1];

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode; one wait cycle so reads come from a registered answer
  logic ack_r;
  wire  req       = avs_read | avs_write;
  wire  hit_wdctl = avs_address == CTWD_ADDR_WDCTL;
  wire  hit_mask  = avs_address == CTWD_ADDR_MASK;
  wire  hit_flag  = avs_address == CTWD_ADDR_FLAG;
  wire  hit_stat  = avs_address == CTWD_ADDR_STAT;
  wire  hit_any   = hit_wdctl | hit_mask | hit_flag | hit_stat;
  wire  lane0     = avs_byteenable[0];
  wire  wr_go     = avs_write & ack_r & lane0;
  wire  wr_wdctl  = wr_go & hit_wdctl;
  wire  wr_mask   = wr_go & hit_mask;
  wire  wr_flag   = wr_go & hit_flag;
  assign avs_waitrequest = req & ~ack_r;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) ack_r <= 1'b0;
    else if (clk_en) ack_r <= req & ~ack_r;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Prescaler: divide by PRS_BASE times (setting + 1)
  localparam int PW = $clog2(PRS_BASE * 16) + 1;
  logic [PW-1:0] prs_cnt_r;
  wire  [PW-1:0] prs_n     = PW'(prescaler_setting) + PW'(1);
  wire  [PW-1:0] prs_limit = PW'(PRS_BASE) * prs_n - PW'(1);
  wire           prs_tick  = prs_cnt_r >= prs_limit;   // R02

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) prs_cnt_r <= '0;
    else if (clk_en && !sleeping) prs_cnt_r <= prs_tick ? '0 : prs_cnt_r + PW'(1); // R03
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock timer; its top bit is the 1 Hz signal
  logic [CTWD_TMR_WIDTH-1:0] tmr_r;
  wire  [CTWD_TMR_WIDTH-1:0] tmr_nxt = tmr_r + CTWD_TMR_WIDTH'(1);
  wire  tmr_advance = clk_en & ~sleeping & prs_tick;                 // R03
  wire  sec_fall    = tmr_advance & tmr_r[CTWD_TMR_WIDTH-1]
                      & ~tmr_nxt[CTWD_TMR_WIDTH-1];                  // R04

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) tmr_r <= '0;                                         // R20
    else if (tmr_advance) tmr_r <= tmr_nxt;                          // R01
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers
  logic wd_enable_r;
  logic mask_r;
  logic flag_r;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wd_enable_r <= CTWD_RST_ENABLE;                                // R08 R15
      mask_r      <= CTWD_RST_MASK;                                  // R16
    end else if (clk_en) begin
      if (wr_wdctl) wd_enable_r <= avs_writedata[CTWD_BIT_ENABLE];   // R08
      if (wr_mask)  mask_r      <= avs_writedata[CTWD_BIT_MASK];     // R16
    end
  end

  // Set beats a same-cycle clear so no tick is lost
  wire flag_clr = wr_flag & avs_writedata[CTWD_BIT_FLAG];            // R18
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) flag_r <= CTWD_RST_FLAG;
    else if (clk_en) begin
      if (sec_fall) flag_r <= 1'b1;                                  // R04 R05
      else if (flag_clr) flag_r <= 1'b0;                             // R18
    end
  end
  assign second_tick_irq = flag_r & mask_r;                          // R05

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog counter and overflow
  logic [CTWD_WD_WIDTH-1:0] wd_r;
  logic                     nmi_r;
  wire  wd_restart = wr_wdctl & avs_writedata[CTWD_BIT_RESTART];     // R09
  wire  wd_count   = sec_fall & wd_enable_r;                         // R06 R19
  wire  wd_ovf     = wd_count & (&wd_r);                             // R07
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) wd_r <= '0;                                          // R20
    else if (clk_en) begin
      if (sleeping || wd_restart) wd_r <= '0;                        // R12 R19
      else if (wd_count) wd_r <= wd_r + CTWD_WD_WIDTH'(1);           // R06 R10 R11
    end
  end

  // NMI stays pending until the stack pointer pair is written
  logic sp_low_seen_r;
  logic sp_ready_r;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sp_low_seen_r <= 1'b0;
      sp_ready_r    <= 1'b0;
    end else if (clk_en) begin
      if (spl_sync_r[1]) begin
        sp_low_seen_r <= 1'b1;
        sp_ready_r    <= 1'b0;
      end
      if (sph_sync_r[1] && sp_low_seen_r) sp_ready_r <= 1'b1;        // R13
    end
  end

  logic nmi_pend_r;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      nmi_pend_r <= 1'b0;
      nmi_r      <= 1'b0;
    end else if (clk_en) begin
      nmi_r <= 1'b0;
      if (wd_ovf) nmi_pend_r <= 1'b1;                                // R07
      else if (nmi_pend_r && sp_ready_r && wd_enable_r) begin
        nmi_pend_r <= 1'b0;
        nmi_r      <= 1'b1;                                          // R13
      end
      if (!wd_enable_r) nmi_pend_r <= 1'b0;                          // R19
    end
  end
  assign watchdog_nmi = nmi_r;
  assign halt_release = nmi_r;                                       // R11
  assign nmi_vector   = CTWD_NMI_VECTOR;                             // R14

  ////////////////////////////////////////////////////////////////////////////
  // Read data; unused bits and restart read zero
  logic [31:0] rdata_r;
  wire  [31:0] rd_wdctl = 32'(wd_enable_r) << CTWD_BIT_ENABLE;       // R15 R17
  wire  [31:0] rd_mask  = 32'(mask_r) << CTWD_BIT_MASK;              // R17
  wire  [31:0] rd_flag  = 32'(flag_r) << CTWD_BIT_FLAG;              // R17
  wire  [31:0] rd_stat  = {20'h00000, nmi_pend_r, sp_ready_r, wd_r, tmr_r};
  wire  [31:0] rd_mux   = hit_wdctl ? rd_wdctl :
                          hit_mask  ? rd_mask  :
                          hit_flag  ? rd_flag  :
                          hit_stat  ? rd_stat  : 32'h00000000;
  logic [1:0]  resp_r;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= 32'h00000000;
      resp_r  <= 2'h0;
    end else if (clk_en) begin
      rdata_r <= (avs_read & ~ack_r) ? rd_mux : 32'h00000000;
      resp_r  <= (req & ~ack_r & ~hit_any) ? 2'h2 : 2'h0;
    end
  end
  assign avs_readdata = rdata_r;
  assign avs_response = resp_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_flag_on_tick: assert property (@(posedge sys_clk) disable iff (!rst_n)
    sec_fall |=> flag_r) else $error("flag not set on tick"); // R04
  a_mask_gates_irq: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !mask_r |-> !second_tick_irq) else $error("masked irq seen"); // R05
  a_restart_clears: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clk_en && wd_restart) |=> wd_r == '0) else $error("restart failed"); // R09
  a_sleep_holds_wd: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clk_en && sleeping) |=> wd_r == '0) else $error("wd count in sleep"); // R12
  a_sleep_stops_tmr: assert property (@(posedge sys_clk) disable iff (!rst_n)
    sleeping |=> $stable(tmr_r)) else $error("timer ran in sleep"); // R03
  a_disabled_no_nmi: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !wd_enable_r |=> !watchdog_nmi) else $error("nmi while disabled"); // R19
  a_nmi_needs_sp: assert property (@(posedge sys_clk) disable iff (!rst_n)
    watchdog_nmi |-> $past(sp_ready_r)) else $error("nmi before sp pair"); // R13
  a_ovf_pends: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clk_en && wd_ovf) |=> nmi_pend_r) else $error("overflow lost"); // R07
  a_flag_clear: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clk_en && flag_clr && !sec_fall) |=> !flag_r) else $error("flag clear"); // R18

  ////////////////////////////////////////////////////////////////////////////
  // Further checks on counting, register and interrupt behaviour
  // Timer steps by one on every prescaler tick
  a_tmr_steps: assert property (@(posedge sys_clk) disable iff (!rst_n) // R01
    tmr_advance
    |=> tmr_r == $past(tmr_nxt))
    else $error("timer step wrong");

  // Timer holds between prescaler ticks
  a_tmr_idle: assert property (@(posedge sys_clk) disable iff (!rst_n) // R01
    !tmr_advance
    |=> $stable(tmr_r))
    else $error("timer moved without tick");

  // Prescaler wraps to zero at its limit
  a_prs_wrap: assert property (@(posedge sys_clk) disable iff (!rst_n) // R02
    (clk_en && !sleeping && prs_tick)
    |=> prs_cnt_r == '0)
    else $error("prescaler did not wrap");

  // Prescaler counts up below its limit
  a_prs_count: assert property (@(posedge sys_clk) disable iff (!rst_n) // R02
    (clk_en && !sleeping && !prs_tick)
    |=> prs_cnt_r == $past(prs_cnt_r) + PW'(1))
    else $error("prescaler count wrong");

  // Oscillator stopped: prescaler frozen too
  a_prs_frozen: assert property (@(posedge sys_clk) disable iff (!rst_n) // R03
    (clk_en && sleeping)
    |=> $stable(prs_cnt_r))
    else $error("prescaler ran in sleep");

  // An unmasked pending flag always reaches the core
  a_irq_follows: assert property (@(posedge sys_clk) disable iff (!rst_n) // R05
    (mask_r && flag_r)
    |-> second_tick_irq)
    else $error("unmasked irq missing");

  // Flag is set even while the request is masked
  a_flag_masked: assert property (@(posedge sys_clk) disable iff (!rst_n) // R05
    (clk_en && sec_fall && !mask_r)
    |=> flag_r)
    else $error("masked tick lost flag");

  // Watchdog advances by one per enabled tick
  a_wd_step: assert property (@(posedge sys_clk) disable iff (!rst_n) // R06
    (clk_en && wd_count && !sleeping && !wd_restart && !(&wd_r))
    |=> wd_r == $past(wd_r) + CTWD_WD_WIDTH'(1))
    else $error("watchdog step wrong");

  // Overflow wraps the watchdog to zero
  a_ovf_wraps: assert property (@(posedge sys_clk) disable iff (!rst_n) // R07
    (clk_en && wd_ovf && !sleeping && !wd_restart)
    |=> wd_r == '0)
    else $error("watchdog did not wrap");

  // Disabling drops any pending interrupt
  a_wd_off_drops: assert property (@(posedge sys_clk) disable iff (!rst_n) // R19
    (clk_en && !wd_enable_r)
    |=> !nmi_pend_r)
    else $error("pending nmi kept while disabled");

  // Disabled watchdog does not count
  a_wd_stalls: assert property (@(posedge sys_clk) disable iff (!rst_n) // R19
    (clk_en && !wd_enable_r && !sleeping && !wd_restart)
    |=> $stable(wd_r))
    else $error("disabled watchdog counted");

  // Interrupt is a single-cycle pulse
  a_nmi_pulse: assert property (@(posedge sys_clk) disable iff (!rst_n) // R07
    (clk_en && watchdog_nmi)
    |=> !watchdog_nmi)
    else $error("nmi longer than one cycle");

  // No interrupt before the stack pointer pair
  a_nmi_waits_sp: assert property (@(posedge sys_clk) disable iff (!rst_n) // R13
    (clk_en && !sp_ready_r)
    |=> !watchdog_nmi)
    else $error("nmi without sp pair");

  // Pending interrupt is delivered once the pair is in
  a_nmi_fires: assert property (@(posedge sys_clk) disable iff (!rst_n) // R13
    (clk_en && nmi_pend_r && sp_ready_r && wd_enable_r && !wd_ovf)
    |=> watchdog_nmi)
    else $error("pending nmi not sent");

  // The interrupt also wakes a halted core
  a_halt_with_nmi: assert property (@(posedge sys_clk) disable iff (!rst_n) // R11
    watchdog_nmi
    |-> halt_release)
    else $error("nmi without halt release");

  // A fresh low half cancels readiness until the high half follows
  a_sp_pair: assert property (@(posedge sys_clk) disable iff (!rst_n) // R13
    (clk_en && spl_sync_r[1])
    |=> !sp_ready_r)
    else $error("sp ready without pair");

  // Enable bit takes written value
  a_enable_write: assert property (@(posedge sys_clk) disable iff (!rst_n) // R08
    (clk_en && wr_wdctl)
    |=> wd_enable_r == $past(avs_writedata[CTWD_BIT_ENABLE]))
    else $error("enable write lost");

  // Mask bit takes written value
  a_mask_write: assert property (@(posedge sys_clk) disable iff (!rst_n) // R16
    (clk_en && wr_mask)
    |=> mask_r == $past(avs_writedata[CTWD_BIT_MASK]))
    else $error("mask write lost");

  // Writing zero to the flag changes nothing
  a_flag_zero_noop: assert property (@(posedge sys_clk) disable iff (!rst_n) // R18
    (clk_en && wr_flag && !avs_writedata[CTWD_BIT_FLAG] && !sec_fall)
    |=> $stable(flag_r))
    else $error("zero write moved flag");

  // Restart bit always reads as zero
  a_restart_reads0: assert property (@(posedge sys_clk) disable iff (!rst_n) // R15
    (avs_read && ack_r && hit_wdctl)
    |-> !avs_readdata[CTWD_BIT_RESTART])
    else $error("restart bit read as one");

  // Unused control bits read as zero
  a_unused_zero: assert property (@(posedge sys_clk) disable iff (!rst_n) // R17
    (avs_read && ack_r && !hit_stat)
    |-> avs_readdata[31:CTWD_BIT_ENABLE+1] == '0)
    else $error("unused bits not zero");

  // Exactly one wait cycle per request
  a_one_wait: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clk_en && req && avs_waitrequest)
    |=> !avs_waitrequest)
    else $error("more than one wait cycle");

  // Unmapped addresses answer with an error code
  a_unmapped_resp: assert property (@(posedge sys_clk) disable iff (!rst_n) // R17
    (clk_en && req && !ack_r && !hit_any)
    |=> avs_response == 2'h2)
    else $error("unmapped access not flagged");

endmodule

/* File: tb/ctwd_core_model.sv */
// Behavioural processor core: pairs stack pointer writes, takes the watchdog interrupt
`timescale 1ns/1ps
module ctwd_core_model (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        pair_go,
  input  wire logic        watchdog_nmi,
  input  wire logic        halt_release,
  input  wire logic [15:0] nmi_vector,
  output logic             sp_lo,
  output logic             sp_hi,
  output logic [7:0]       nmi_seen,
  output logic [7:0]       nmi_bad
);
  ////////////////////////////////////////////////////////////////////////////
  // Low half then high half, one cycle each, as the core writes them
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sp_lo <= 1'b0;
      sp_hi <= 1'b0;
    end else begin
      sp_lo <= pair_go;
      sp_hi <= sp_lo;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Taken even with interrupts disabled; a wrong vector or no wake is counted
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      nmi_seen <= 8'h00;
      nmi_bad  <= 8'h00;
    end else if (watchdog_nmi) begin
      nmi_seen <= nmi_seen + 8'h01;
      if (nmi_vector !== 16'h0100 || halt_release !== 1'b1) begin
        nmi_bad <= nmi_bad + 8'h01;
      end
    end
  end
endmodule

/* File: tb/ctwd_timer_bench.sv */
// Self-checking bench for the clock timer and watchdog block
`timescale 1ns/1ps
module ctwd_timer_bench;
  import ctwd_pkg::*;
  localparam int P = 1024; // Tick period: 256 inputs of 2 x n cycles, n = 2
  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [17:0] avs_address = 18'h00000;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, rdat;
  logic        avs_waitrequest, second_tick_irq, watchdog_nmi, halt_release;
  logic [1:0]  avs_response, rresp;
  logic        sleep_mode = 1'b0;
  logic        pair_go = 1'b0;
  logic        sp_lo, sp_hi;
  logic [15:0] nmi_vector;
  logic [7:0]  nmi_seen, nmi_bad;
  int          n_errors = 0;
  int          checked = 0;
  int          cyc = 0;
  ////////////////////////////////////////////////////////////////////////////
  // Clock and cycle count
  always #12.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) cyc <= cyc + 1;
  ctwd_timer #(.PRS_BASE(2)) u_ctwd_timer (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(1'b1),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
    .prescaler_setting(4'h1), .sleep_mode(sleep_mode), .stack_pointer_low_half(sp_lo),
    .stack_pointer_high_half(sp_hi), .second_tick_irq(second_tick_irq),
    .watchdog_nmi(watchdog_nmi), .nmi_vector(nmi_vector), .halt_release(halt_release));
  ctwd_core_model u_ctwd_core_model (.sys_clk(sys_clk), .rst_n(rst_n), .pair_go(pair_go),
    .watchdog_nmi(watchdog_nmi), .halt_release(halt_release), .nmi_vector(nmi_vector),
    .sp_lo(sp_lo), .sp_hi(sp_hi), .nmi_seen(nmi_seen), .nmi_bad(nmi_bad));
  ////////////////////////////////////////////////////////////////////////////
  // Verdict, comparison and bus tasks
  task conclude();
    if (n_errors == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      n_errors++;
      $display("BAD %0t seen %h expected %h", $time, s, e);
    end
  endtask
  // Request held until the rising edge that sees waitrequest low; data taken there
  task bus(input logic wr, input logic [17:0] a, input logic [31:0] d);
    int i;
    @(posedge sys_clk);
    avs_address <= a;
    avs_read <= !wr;
    avs_write <= wr;
    avs_writedata <= d;
    for (i = 0; i < 50; i++) begin
      @(posedge sys_clk);
      if (avs_waitrequest === 1'b0) break;
    end
    if (i == 50) begin
      n_errors++;
      conclude();
    end
    rdat = avs_readdata;
    rresp = avs_response;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task wait_irq();
    int i;
    for (i = 0; i < 2 * P; i++) begin
      @(negedge sys_clk);
      if (second_tick_irq === 1'b1) break;
    end
    if (i == 2 * P) begin
      n_errors++;
      conclude();
    end
  endtask
  // Interrupt must land three to four ticks after the counter was cleared
  task wd_window(input int t0);
    logic [7:0] n0;
    n0 = nmi_seen;
    while (nmi_seen === n0 && cyc - t0 < 5 * P) @(negedge sys_clk);
    chk(cyc - t0 >= 3 * P - 8 && cyc - t0 <= 4 * P + 8, 1);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task t_regs();
    bus(0, CTWD_ADDR_WDCTL, 0);
    chk(rdat, 2);
    bus(0, CTWD_ADDR_MASK, 0);
    chk(rdat, 0);
    bus(0, CTWD_ADDR_FLAG, 0);
    chk(rdat, 0);
    bus(0, 18'h00020, 0);
    chk({rdat, rresp}, {32'h0, 2'b10});
  endtask
  task t_tick();
    int t1;
    bus(1, CTWD_ADDR_WDCTL, 0);
    repeat (P + 32) @(posedge sys_clk);
    bus(0, CTWD_ADDR_FLAG, 0);
    chk({rdat, second_tick_irq}, {32'h1, 1'b0});
    bus(1, CTWD_ADDR_FLAG, 0);
    bus(0, CTWD_ADDR_FLAG, 0);
    chk(rdat, 1);
    bus(1, CTWD_ADDR_FLAG, 1);
    bus(0, CTWD_ADDR_FLAG, 0);
    chk(rdat, 0);
    bus(1, CTWD_ADDR_MASK, 32'hF);
    bus(0, CTWD_ADDR_MASK, 0);
    chk(rdat, 1);
    bus(1, CTWD_ADDR_WDCTL, 32'hC);
    bus(0, CTWD_ADDR_WDCTL, 0);
    chk(rdat, 0);
    wait_irq();
    t1 = cyc;
    bus(1, CTWD_ADDR_FLAG, 1);
    wait_irq();
    chk(cyc - t1, P);
    repeat (2 * P) @(posedge sys_clk);
    chk(nmi_seen, 0);
  endtask
  task t_watchdog();
    bus(1, CTWD_ADDR_WDCTL, 3);
    wd_window(cyc);
    chk(nmi_bad, 0);
    bus(0, CTWD_ADDR_WDCTL, 0);
    chk(rdat, 2);
  endtask
  task t_sleep();
    bus(1, CTWD_ADDR_WDCTL, 3);
    repeat (2 * P + 64) @(posedge sys_clk);
    sleep_mode <= 1'b1;
    repeat (64) @(posedge sys_clk);
    sleep_mode <= 1'b0;
    wd_window(cyc);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    pair_go <= 1'b1;
    @(posedge sys_clk);
    pair_go <= 1'b0;
    t_regs();
    t_tick();
    t_watchdog();
    t_sleep();
    conclude();
  end
endmodule
